// >>> design/ccl_top.sv
// Control, output and interrupt logic around two analog comparators.
// Assumes comparator raw outcomes and the timer clock source are synchronous to clk.
// Function
// - Enable bit set runs the comparator; cleared disables it with no active power.
// - Status bit is one when positive exceeds negative, or below when inverted.
// - Invert bit flips the result for both status bit and pin output.
// - Drive enable puts the result on the pin when its direction is output.
// - Speed bit selects fast normal power when set, slow low power when clear; resets to one.
// - Hysteresis bit enables comparator input hysteresis when set.
// - With sync set, timer and pin result change only on timer clock falling edge.
// - With sync clear, timer and pin result follow the comparator directly.
// - Primary control bit 3 is unused, reads zero, ignores writes.
// - Two comparators each own an identical primary control register.
// - Secondary register holds rise select, fall select, positive and negative channels.
// - Shared mirror shows comparator two at bit 1, one at bit 0, rest zero.
// - Flag register holds comparator two flag at bit 6, one at bit 5; enables match.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module ccl_top
  import ccl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ccl_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ccl_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [ccl_pkg::DATA_W-1:0] regRdata,
  input wire logic [1:0] cmpRaw,
  input wire logic timerClk,
  input wire logic [1:0] pinDirection,
  output logic [1:0] cmpEnable,
  output logic [1:0] cmpSpeedPowerSelect,
  output logic [1:0] cmpHysteresisEnable,
  output logic [1:0][1:0] positiveChannelSelect,
  output logic [1:0][2:0] negativeChannelSelect,
  output logic [1:0] timerOneCmp,
  output logic [1:0] cmpPinOut,
  output logic [1:0] cmpPinOe,
  output logic irq
);

  function automatic logic [3:0] ctlAddr(input int idx);
    ctlAddr = (idx == 0) ? ADDR_CTL_ONE : ADDR_CTL_TWO;
  endfunction : ctlAddr

  function automatic logic [3:0] secAddr(input int idx);
    secAddr = (idx == 0) ? ADDR_SEC_ONE : ADDR_SEC_TWO;
  endfunction : secAddr

  function automatic int flagBit(input int idx);
    flagBit = (idx == 0) ? FLAG_ONE : FLAG_TWO;
  endfunction : flagBit

  // Primary register read view with live result and zero in the unused bit.
  function automatic logic [7:0] ctlView(input logic [7:0] ctl, input logic res);
    logic [7:0] v;
    v = ctl & CTL_WR_MASK;
    v[BIT_RESULT] = res;
    v[BIT_UNUSED] = 1'b0;
    ctlView = v;
  endfunction : ctlView

  logic [1:0] rstPipe;
  logic rstN;
  ccl_state_s r;
  ccl_state_s n;
  logic [1:0] polarized;
  logic [1:0] edgeEvent;
  logic timerFall;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  assign timerFall = r.timerClkPrev & ~timerClk;

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : gCmp
      // A disabled comparator gives a zero result.
      assign polarized[g] = r.ctl[g][BIT_ENABLE] & (cmpRaw[g] ^ r.ctl[g][BIT_INVERT]);
      assign edgeEvent[g] = (polarized[g] & ~r.prevResult[g] & r.sec[g][BIT_RISE]) |
                            (~polarized[g] & r.prevResult[g] & r.sec[g][BIT_FALL]);
      assign cmpEnable[g] = r.ctl[g][BIT_ENABLE];
      assign cmpSpeedPowerSelect[g] = r.ctl[g][BIT_SPEED];
      assign cmpHysteresisEnable[g] = r.ctl[g][BIT_HYST];
      assign positiveChannelSelect[g] = r.sec[g][POS_LSB+1:POS_LSB];
      assign negativeChannelSelect[g] = r.sec[g][NEG_LSB+2:NEG_LSB];
      assign timerOneCmp[g] = r.delivered[g];
      assign cmpPinOut[g] = r.delivered[g];
      assign cmpPinOe[g] = r.ctl[g][BIT_DRIVE] & ~pinDirection[g];
    end
  endgenerate

  assign irq = |(r.flags & r.enables & IRQ_MASK);
  assign regRdata = r.rdata;

  always_comb begin
    n = r;
    n.timerClkPrev = timerClk;
    n.rdata = 8'h00;
    for (int i = 0; i < NUM_CMP; i++) begin
      if (regWrite && regAddr == ctlAddr(i)) begin
        n.ctl[i] = regWdata & CTL_WR_MASK;
      end
      if (regWrite && regAddr == secAddr(i)) begin
        n.sec[i] = regWdata;
      end
      if (r.ctl[i][BIT_SYNC]) begin
        if (timerFall) begin
          n.delivered[i] = polarized[i];
        end
      end else begin
        n.delivered[i] = polarized[i];
      end
      n.prevResult[i] = polarized[i];
      if (regWrite && regAddr == ADDR_FLAGS && regWdata[flagBit(i)]) begin
        n.flags[flagBit(i)] = 1'b0;
      end
      // A new edge wins over a clear in the same cycle.
      if (edgeEvent[i]) begin
        n.flags[flagBit(i)] = 1'b1;
      end
    end
    if (regWrite && regAddr == ADDR_ENABLES) begin
      n.enables = regWdata & IRQ_MASK;
    end
    if (regRead) begin
      if (regAddr == ADDR_CTL_ONE) begin
        n.rdata = ctlView(r.ctl[0], polarized[0]);
      end else if (regAddr == ADDR_CTL_TWO) begin
        n.rdata = ctlView(r.ctl[1], polarized[1]);
      end else if (regAddr == ADDR_SEC_ONE) begin
        n.rdata = r.sec[0];
      end else if (regAddr == ADDR_SEC_TWO) begin
        n.rdata = r.sec[1];
      end else if (regAddr == ADDR_MIRROR) begin
        n.rdata = {6'h00, polarized};
      end else if (regAddr == ADDR_FLAGS) begin
        n.rdata = r.flags & IRQ_MASK;
      end else if (regAddr == ADDR_ENABLES) begin
        n.rdata = r.enables & IRQ_MASK;
      end else begin
        n.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      r.ctl <= {CTL_RESET, CTL_RESET};
      r.sec <= {SEC_RESET, SEC_RESET};
      r.flags <= IRQ_RESET;
      r.enables <= IRQ_RESET;
      r.prevResult <= 2'h0;
      r.delivered <= 2'h0;
      r.timerClkPrev <= 1'b0;
      r.rdata <= 8'h00;
    end else begin
      r <= n;
    end
  end

  // Checks kept beside the logic.

  property p_disabled_reads_zero;
    @(posedge clk) disable iff (!rstN)
      (regRead && regAddr == ADDR_CTL_ONE && !cmpEnable[0]) |=> (regRdata[BIT_RESULT] == 1'b0);
  endproperty
  a_disabled_reads_zero: assert property (p_disabled_reads_zero)
    else $error("Disabled comparator reports a one result.");

  property p_status_polarity;
    @(posedge clk) disable iff (!rstN)
      (regRead && regAddr == ADDR_CTL_TWO && cmpEnable[1]) |=>
        (regRdata[BIT_RESULT] == ($past(cmpRaw[1]) ^ regRdata[BIT_INVERT]));
  endproperty
  a_status_polarity: assert property (p_status_polarity)
    else $error("Status bit disagrees with input and polarity.");

  property p_invert_reaches_pin;
    @(posedge clk) disable iff (!rstN)
      (cmpEnable[0] && !r.ctl[0][BIT_SYNC] && !$past(r.ctl[0][BIT_SYNC])) |=>
        (cmpPinOut[0] == ($past(cmpRaw[0]) ^ $past(r.ctl[0][BIT_INVERT])));
  endproperty
  a_invert_reaches_pin: assert property (p_invert_reaches_pin)
    else $error("Pin output ignores the invert select.");

  property p_pin_drive;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_CTL_ONE && regWdata[BIT_DRIVE] && !regWdata[BIT_ENABLE]) ##1
        !pinDirection[0] |-> cmpPinOe[0];
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("Pin not driven with drive enable and output direction.");

  property p_speed_write;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_CTL_TWO) |=>
        (cmpSpeedPowerSelect[1] == $past(regWdata[BIT_SPEED])) &&
        (cmpHysteresisEnable[1] == $past(regWdata[BIT_HYST]));
  endproperty
  a_speed_write: assert property (p_speed_write)
    else $error("Speed or hysteresis select did not follow the write.");

  property p_sync_hold;
    @(posedge clk) disable iff (!rstN)
      (r.ctl[0][BIT_SYNC] && !timerFall) |=> $stable(cmpPinOut[0]) && $stable(timerOneCmp[0]);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("Synchronised output changed without a timer falling edge.");

  property p_sync_capture;
    @(posedge clk) disable iff (!rstN)
      (r.ctl[1][BIT_SYNC] && timerFall) |=> (timerOneCmp[1] == $past(polarized[1]));
  endproperty
  a_sync_capture: assert property (p_sync_capture)
    else $error("Synchronised output missed the timer falling edge.");

  property p_async_follow;
    @(posedge clk) disable iff (!rstN)
      !r.ctl[1][BIT_SYNC] |=> (timerOneCmp[1] == $past(polarized[1]));
  endproperty
  a_async_follow: assert property (p_async_follow)
    else $error("Unsynchronised output lags the comparator.");

  property p_unused_bit;
    @(posedge clk) disable iff (!rstN)
      (regRead && (regAddr == ADDR_CTL_ONE || regAddr == ADDR_CTL_TWO)) |=>
        (regRdata[BIT_UNUSED] == 1'b0);
  endproperty
  a_unused_bit: assert property (p_unused_bit)
    else $error("Unused control bit read as one.");

  property p_secondary_readback;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_SEC_ONE) ##1
        (regRead && regAddr == ADDR_SEC_ONE && !regWrite) |=>
        (regRdata == $past(regWdata, 2));
  endproperty
  a_secondary_readback: assert property (p_secondary_readback)
    else $error("Secondary control readback differs from the write.");

  property p_mirror;
    @(posedge clk) disable iff (!rstN)
      (regRead && regAddr == ADDR_MIRROR) |=> (regRdata == {6'h00, $past(polarized)});
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("Mirror register does not show both results.");

  property p_edge_sets_flag;
    @(posedge clk) disable iff (!rstN)
      (polarized[0] && !r.prevResult[0] && r.sec[0][BIT_RISE]) |=> r.flags[FLAG_ONE];
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag)
    else $error("Rising edge did not set the flag.");

  property p_flag_sticky;
    @(posedge clk) disable iff (!rstN)
      (r.flags[FLAG_TWO] && !(regWrite && regAddr == ADDR_FLAGS && regWdata[FLAG_TWO])) |=>
        r.flags[FLAG_TWO] ##1 (irq || !r.enables[FLAG_TWO] || !r.flags[FLAG_TWO]);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Flag dropped without a clear or interrupt missing.");

  property p_enable_write;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_CTL_ONE) |=> (cmpEnable[0] == $past(regWdata[BIT_ENABLE]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Enable output did not follow the write.");

  property p_disabled_mirror_low;
    @(posedge clk) disable iff (!rstN)
      (regRead && regAddr == ADDR_MIRROR && !cmpEnable[1]) |=>
        (regRdata[1] == 1'b0);
  endproperty
  a_disabled_mirror_low: assert property (p_disabled_mirror_low)
    else $error("Disabled comparator shows a one in the mirror.");

  property p_speed_reset;
    @(posedge clk)
      $rose(rstN) |-> (cmpSpeedPowerSelect == 2'h3) && (cmpHysteresisEnable == 2'h0);
  endproperty
  a_speed_reset: assert property (p_speed_reset)
    else $error("Speed select not one after reset.");

  property p_control_one_write;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_CTL_ONE) |=>
        (cmpSpeedPowerSelect[0] == $past(regWdata[BIT_SPEED])) &&
        (cmpHysteresisEnable[0] == $past(regWdata[BIT_HYST]));
  endproperty
  a_control_one_write: assert property (p_control_one_write)
    else $error("Comparator one speed or hysteresis did not follow the write.");

  property p_drive_off;
    @(posedge clk) disable iff (!rstN)
      (!r.ctl[1][BIT_DRIVE] || pinDirection[1]) |-> !cmpPinOe[1];
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("Pin driven without drive enable and output direction.");

  property p_drive_on;
    @(posedge clk) disable iff (!rstN)
      (r.ctl[0][BIT_DRIVE] && !pinDirection[0]) |-> cmpPinOe[0];
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("Pin not driven although drive enable is set.");

  property p_async_follow_one;
    @(posedge clk) disable iff (!rstN)
      !r.ctl[0][BIT_SYNC] |=> (timerOneCmp[0] == $past(polarized[0]));
  endproperty
  a_async_follow_one: assert property (p_async_follow_one)
    else $error("Unsynchronised comparator one output lags.");

  property p_sync_capture_one;
    @(posedge clk) disable iff (!rstN)
      (r.ctl[0][BIT_SYNC] && timerFall) |=> (cmpPinOut[0] == $past(polarized[0]));
  endproperty
  a_sync_capture_one: assert property (p_sync_capture_one)
    else $error("Comparator one pin missed the timer falling edge.");

  property p_unused_stored_zero;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_CTL_TWO) |=> !r.ctl[1][BIT_UNUSED];
  endproperty
  a_unused_stored_zero: assert property (p_unused_stored_zero)
    else $error("Unused control bit was stored.");

  property p_sec_one_write;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_SEC_ONE) |=>
        (positiveChannelSelect[0] == $past(regWdata[POS_LSB+1:POS_LSB])) &&
        (negativeChannelSelect[0] == $past(regWdata[NEG_LSB+2:NEG_LSB]));
  endproperty
  a_sec_one_write: assert property (p_sec_one_write)
    else $error("Comparator one channel selects did not follow the write.");

  property p_sec_two_write;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_SEC_TWO) |=>
        (positiveChannelSelect[1] == $past(regWdata[POS_LSB+1:POS_LSB])) &&
        (negativeChannelSelect[1] == $past(regWdata[NEG_LSB+2:NEG_LSB]));
  endproperty
  a_sec_two_write: assert property (p_sec_two_write)
    else $error("Comparator two channel selects did not follow the write.");

  property p_flags_upper_zero;
    @(posedge clk) disable iff (!rstN)
      (regRead && regAddr == ADDR_FLAGS) |=>
        ((regRdata & ~IRQ_MASK) == 8'h00);
  endproperty
  a_flags_upper_zero: assert property (p_flags_upper_zero)
    else $error("Flag register shows a bit outside the two flags.");

  property p_enables_write;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_ENABLES) |=>
        (r.enables == ($past(regWdata) & IRQ_MASK));
  endproperty
  a_enables_write: assert property (p_enables_write)
    else $error("Interrupt enables did not follow the write.");

  property p_fall_sets_flag;
    @(posedge clk) disable iff (!rstN)
      (!polarized[1] && r.prevResult[1] && r.sec[1][BIT_FALL]) |=> r.flags[FLAG_TWO];
  endproperty
  a_fall_sets_flag: assert property (p_fall_sets_flag)
    else $error("Falling edge did not set the flag.");

  property p_clear_flag;
    @(posedge clk) disable iff (!rstN)
      (regWrite && regAddr == ADDR_FLAGS && regWdata[FLAG_ONE] && !edgeEvent[0]) |=>
        !r.flags[FLAG_ONE];
  endproperty
  a_clear_flag: assert property (p_clear_flag)
    else $error("Writing a one did not clear the flag.");

  property p_no_event_no_flag;
    @(posedge clk) disable iff (!rstN)
      (!r.flags[FLAG_TWO] && !edgeEvent[1]) |=> !r.flags[FLAG_TWO];
  endproperty
  a_no_event_no_flag: assert property (p_no_event_no_flag)
    else $error("Flag set without an enabled edge.");

endmodule : ccl_top

// >>> dv/ccl_analog_model.sv
// Behavioural model of the two analog comparator cores and the timer one clock source.
// Assumes the bench sets the analog input relation and whether the timer clock runs.
`timescale 1ns/1ps
module ccl_analog_model (
  input wire logic clk,
  input wire logic [1:0] cmpEnable,
  input wire logic [1:0] posAbove,
  input wire logic timerRun,
  output logic [1:0] cmpRaw,
  output logic timerClk
);
  logic [1:0] divCnt = 2'h0;
  logic [1:0] junk = 2'h1;
  // A disabled core gives no valid answer, so its output wanders every cycle.
  always @(posedge clk) begin
    junk <= ~junk;
    divCnt <= divCnt + 2'h1;
    timerClk <= timerRun & divCnt[1];
    cmpRaw <= (cmpEnable & posAbove) | (~cmpEnable & junk);
  end
endmodule : ccl_analog_model

// >>> dv/tb_ccl_top.sv
// Self-checking bench of the comparator control logic through its register port.
// Assumes the analog model stands on the far side of the comparator and timer ports.
`timescale 1ns/1ps
module tb_ccl_top;
  import ccl_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [1:0] posAbove = 2'h0;
  logic [1:0] pinDirection = 2'h0;
  logic timerRun = 1'b0;
  logic [7:0] regRdata;
  logic [1:0] cmpRaw, cmpEnable, cmpSpeedPowerSelect, cmpHysteresisEnable;
  logic [1:0] timerOneCmp, cmpPinOut, cmpPinOe;
  logic [1:0][1:0] positiveChannelSelect;
  logic [1:0][2:0] negativeChannelSelect;
  logic timerClk, irq;
  int errTotal = 0;
  int nTests = 0;
  logic [7:0] rstVal [8] = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #25 clk = ~clk;
  ccl_top i_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .cmpRaw(cmpRaw),
    .timerClk(timerClk), .pinDirection(pinDirection), .cmpEnable(cmpEnable),
    .cmpSpeedPowerSelect(cmpSpeedPowerSelect), .cmpHysteresisEnable(cmpHysteresisEnable),
    .positiveChannelSelect(positiveChannelSelect),
    .negativeChannelSelect(negativeChannelSelect), .timerOneCmp(timerOneCmp),
    .cmpPinOut(cmpPinOut), .cmpPinOe(cmpPinOe), .irq(irq));
  ccl_analog_model i_model (.clk(clk), .cmpEnable(cmpEnable), .posAbove(posAbove),
    .timerRun(timerRun), .cmpRaw(cmpRaw), .timerClk(timerClk));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask : rd
  task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tallyAndFinish
  initial begin
    #(50 * 5000);
    errTotal++;
    tallyAndFinish();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({6'h0, cmpSpeedPowerSelect}, 8'h03);
    for (int a = 0; a < 8; a++) rd(a[3:0], rstVal[a]);
    wr(ADDR_CTL_ONE, 8'hFF);
    rd(ADDR_CTL_ONE, 8'hF7);
    for (int k = 0; k < 4; k++) begin
      posAbove[0] <= k[0];
      wr(ADDR_CTL_ONE, 8'h84 | {3'h0, k[1], 4'h0});
      rd(ADDR_CTL_ONE, 8'h84 | {1'b0, k[0] ^ k[1], 1'b0, k[1], 4'h0});
      chk({7'h0, timerOneCmp[0]}, {7'h0, k[0] ^ k[1]});
      chk({7'h0, cmpPinOut[0]}, {7'h0, k[0] ^ k[1]});
    end
    wr(ADDR_CTL_ONE, 8'h14);
    rd(ADDR_CTL_ONE, 8'h14);
    chk({6'h0, cmpEnable}, 8'h00);
    wr(ADDR_CTL_ONE, 8'h24);
    chk({6'h0, cmpPinOe}, 8'h01);
    pinDirection <= 2'h1;
    @(posedge clk);
    #1;
    chk({6'h0, cmpPinOe}, 8'h00);
    pinDirection <= 2'h0;
    posAbove[0] <= 1'b0;
    wr(ADDR_CTL_ONE, 8'h85);
    posAbove[0] <= 1'b1;
    rd(ADDR_CTL_ONE, 8'hC5);
    repeat (10) @(posedge clk);
    #1;
    chk({7'h0, timerOneCmp[0]}, 8'h00);
    timerRun <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    chk({7'h0, timerOneCmp[0]}, 8'h01);
    timerRun <= 1'b0;
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= ADDR_SEC_ONE;
    regWdata <= 8'hF7;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, 8'hF7);
    chk({3'h0, positiveChannelSelect[0], negativeChannelSelect[0]}, 8'h1F);
    wr(ADDR_SEC_TWO, 8'h5A);
    rd(ADDR_SEC_TWO, 8'h5A);
    chk({3'h0, positiveChannelSelect[1], negativeChannelSelect[1]}, 8'h0A);
    wr(ADDR_CTL_TWO, 8'h82);
    chk({6'h0, cmpHysteresisEnable}, 8'h02);
    chk({6'h0, cmpSpeedPowerSelect}, 8'h01);
    chk({6'h0, cmpEnable}, 8'h03);
    rd(ADDR_CTL_TWO, 8'h82);
    wr(ADDR_CTL_ONE, 8'h84);
    posAbove <= 2'h2;
    wr(ADDR_MIRROR, 8'hFF);
    rd(ADDR_MIRROR, 8'h02);
    wr(ADDR_FLAGS, 8'h60);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_ENABLES, 8'hFF);
    rd(ADDR_ENABLES, 8'h60);
    wr(ADDR_ENABLES, 8'h20);
    posAbove <= 2'h3;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h0, irq}, 8'h01);
    rd(ADDR_MIRROR, 8'h03);
    rd(ADDR_FLAGS, 8'h20);
    wr(ADDR_ENABLES, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(ADDR_FLAGS, 8'h20);
    rd(ADDR_FLAGS, 8'h00);
    posAbove <= 2'h1;
    repeat (3) @(posedge clk);
    rd(ADDR_FLAGS, 8'h40);
    wr(ADDR_ENABLES, 8'h40);
    chk({7'h0, irq}, 8'h01);
    wr(ADDR_FLAGS, 8'h40);
    posAbove <= 2'h3;
    repeat (3) @(posedge clk);
    rd(ADDR_FLAGS, 8'h00);
    chk({7'h0, irq}, 8'h00);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({6'h0, cmpSpeedPowerSelect}, 8'h03);
    rd(ADDR_CTL_TWO, 8'h04);
    tallyAndFinish();
  end
endmodule : tb_ccl_top

// >>> inc/ccl_pkg.sv
// Shared constants and state type of the comparator control logic.
// Assumes one 20 MHz clock and the register port of the top module.
package ccl_pkg;

  localparam int NUM_CMP = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register addresses on the register port.
  localparam logic [3:0] ADDR_CTL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CTL_TWO = 4'h1;
  localparam logic [3:0] ADDR_SEC_ONE = 4'h2;
  localparam logic [3:0] ADDR_SEC_TWO = 4'h3;
  localparam logic [3:0] ADDR_MIRROR = 4'h4;
  localparam logic [3:0] ADDR_FLAGS = 4'h5;
  localparam logic [3:0] ADDR_ENABLES = 4'h6;

  // Primary control field positions.
  localparam int BIT_ENABLE = 7;
  localparam int BIT_RESULT = 6;
  localparam int BIT_DRIVE = 5;
  localparam int BIT_INVERT = 4;
  localparam int BIT_UNUSED = 3;
  localparam int BIT_SPEED = 2;
  localparam int BIT_HYST = 1;
  localparam int BIT_SYNC = 0;
  localparam logic [7:0] CTL_WR_MASK = 8'hB7;
  localparam logic [7:0] CTL_RESET = 8'h04;

  // Secondary control field positions.
  localparam int BIT_RISE = 7;
  localparam int BIT_FALL = 6;
  localparam int POS_LSB = 4;
  localparam int NEG_LSB = 0;
  localparam logic [7:0] SEC_RESET = 8'h00;

  // Interrupt flag and enable positions.
  localparam int FLAG_ONE = 5;
  localparam int FLAG_TWO = 6;
  localparam logic [7:0] IRQ_MASK = 8'h60;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  typedef struct packed {
    logic [1:0][7:0] ctl;
    logic [1:0][7:0] sec;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [1:0] prevResult;
    logic [1:0] delivered;
    logic timerClkPrev;
    logic [7:0] rdata;
  } ccl_state_s;

endpackage : ccl_pkg
